// ==== cpw_channel.sv ====
// Purpose: One channel's single output latch, shared by compare and PWM modes
// Assumes: Match and time base terms come from the top, same clock
// Notes:   Latch drives the pin only in modes that own the pin

`timescale 1ns/100ps

module cpw_channel
	import cpw_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      rst,
	input  wire cpw_ctrl_t ctrl,
	input  wire logic      ctrl_wr,
	input  wire logic [3:0] wr_mode,
	input  wire logic      cmp_match,
	input  wire logic      pwm_wrap,
	input  wire logic      duty_zero,
	input  wire logic      pwm_hit,
	output cpw_drv_t       drv,
	output logic           match_rise
);

	logic match_q;
	logic out_latch;

	// Match history so a long match raises one event only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= cmp_match;
		end
	end

	assign match_rise = cmp_match && !match_q && is_compare(ctrl.mode);

	// Output latch: preloading mode writes first, then compare, then PWM
	// Other control writes fall through, so a duty-bit write cannot swallow a pin edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_latch <= 1'b0;
		end else if (ctrl_wr && ((wr_mode == MODE_OFF) || (wr_mode == MODE_SET) || (wr_mode == MODE_CLR))) begin
			case (wr_mode)
				MODE_OFF: out_latch <= 1'b0;
				MODE_SET: out_latch <= 1'b0;
				default:  out_latch <= 1'b1;
			endcase
		end else if (match_rise) begin
			case (ctrl.mode)
				MODE_TOGGLE: out_latch <= !out_latch;
				MODE_SET:    out_latch <= 1'b1;
				MODE_CLR:    out_latch <= 1'b0;
				default:     out_latch <= out_latch;
			endcase
		end else if (is_pwm(ctrl.mode)) begin
			// Zero duty never raises the pin
			if (pwm_wrap && !duty_zero) begin
				out_latch <= 1'b1;
			end else if (pwm_hit) begin
				out_latch <= 1'b0;
			end
		end
	end

	assign drv.out   = out_latch;
	assign drv.drive = owns_pin(ctrl.mode);

endmodule : cpw_channel

// ==== cpw_load.sv ====
// Purpose: Far-side load on the first channel's pin, measuring pulses
// Assumes: Pin has a pull-down, so a released pin reads low
// Notes:   Counts are in system clock cycles

`timescale 1ns/100ps

module cpw_load (
	input  wire logic sys_clk,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output int        rise_cnt,
	output int        period_len,
	output int        pulse_len
);
	logic level;
	logic prev = 1'b0;
	int   since;
	int   hi;

	// Pull-down wins whenever the pin is not driven
	assign level = pin_oe ? pin_out : 1'b0;

	// Rise-to-rise period and high time of the last pulse
	always @(posedge sys_clk) begin
		prev <= level;
		if (level && !prev) begin
			rise_cnt   <= rise_cnt + 1;
			period_len <= since;
			since      <= 1;
			hi         <= 1;
		end else begin
			since <= since + 1;
			if (level)
				hi <= hi + 1;
			else if (prev)
				pulse_len <= hi; // Recorded on the first low cycle
		end
	end
endmodule : cpw_load

// ==== cpw_pinmux.sv ====
// Purpose: Routes channel outputs onto port pins in place of port data
// Assumes: Pin 0 first channel, pins 1 and 2 the second's alternatives
// Notes:   Registered, so pins follow the latches by one cycle

`timescale 1ns/100ps

module cpw_pinmux
	import cpw_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire cpw_drv_t   drv_a,
	input  wire cpw_drv_t   drv_b,
	input  wire logic       alt_sel,
	input  wire logic [2:0] port_data,
	input  wire logic [2:0] port_dir,
	output logic [2:0]      pin_out,
	output logic [2:0]      pin_oe
);

	logic [2:0] own;
	logic [2:0] mod_val;

	// Second channel lands on exactly one of its two pins
	assign own     = {drv_b.drive && alt_sel, drv_b.drive && !alt_sel, drv_a.drive};
	assign mod_val = {drv_b.out, drv_b.out, drv_a.out};

	// Reset leaves every pin an input
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_out <= 3'h0;
			pin_oe  <= 3'h0;
		end else begin
			pin_out <= (own & mod_val) | (~own & port_data);
			pin_oe  <= ~port_dir;
		end
	end

endmodule : cpw_pinmux

// ==== cpw_pkg.sv ====
// Purpose: Shared constants and types for the compare and PWM unit
// Assumes: Byte-wide register port, two identical channels
// Notes:   Offsets are register indexes on the plain port

package cpw_pkg;

	// Register offsets; channel two sits one stride above channel one
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_LOW    = 4'h1;
	localparam logic [3:0] OFS_HIGH   = 4'h2;
	localparam logic [3:0] OFS_STRIDE = 4'h3;
	localparam logic [3:0] OFS_ALT    = 4'h6;
	localparam logic [3:0] OFS_FLAGS  = 4'h7;

	// Values after reset
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [7:0] CMP_RST  = 8'h00;
	localparam logic [1:0] LAT_RST  = 2'h0;
	localparam logic       ALT_RST  = 1'h0;

	// Mode select field encodings
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET    = 4'h8;
	localparam logic [3:0] MODE_CLR    = 4'h9;
	localparam logic [3:0] MODE_SWINT  = 4'hA;
	localparam logic [3:0] MODE_TRIG   = 4'hB;

	// Control register: duty low bits above the mode select field
	typedef struct packed {
		logic [1:0] duty_lo;
		logic [3:0] mode;
	} cpw_ctrl_t;

	// Channel drive toward the pin mux
	typedef struct packed {
		logic out;
		logic drive;
	} cpw_drv_t;

	function automatic logic is_pwm(input logic [3:0] mode);
		return mode[3:2] == 2'h3;
	endfunction : is_pwm

	function automatic logic is_compare(input logic [3:0] mode);
		return (mode == MODE_TOGGLE) || (mode[3:2] == 2'h2);
	endfunction : is_compare

	// Only output compare modes and PWM own the pin
	function automatic logic owns_pin(input logic [3:0] mode);
		return is_pwm(mode) || (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLR);
	endfunction : owns_pin

	function automatic logic [3:0] chan_ofs(input logic [3:0] base, input logic ch);
		return base + (ch ? OFS_STRIDE : 4'h0);
	endfunction : chan_ofs

endpackage : cpw_pkg

// ==== cpw_top.sv ====
// Purpose: Two-channel compare and PWM unit with register port
// Assumes: Timers, converter and port latches live outside, on sys_clk
// Notes:   Compare matches are continuous; only sys_clk is used
//
// Operation
// - Zero control write forces compare latch low
// - Selector routes second channel to alternates
// - Mode 1010 sets flag, pin untouched
// - Mode 1011 resets timer, pin untouched
// - Second channel trigger starts enabled conversion
// - Trigger asserts in the cycle of match
// - Timer clears on its next clock edge
// - Trigger reset never sets timer overflow flag
// - Match removed before edge cancels reset
// - Compare needs the system clock running
// - PWM waveform up to ten bits
// - Ten-bit time base from timer plus phase
// - High byte read-only during PWM
// - PWM output replaces port data on pin
// - Zero control write releases pin in PWM
// - Period register sets PWM period
// - Continuous compare; toggle, set, clear, flag
// - At period end clear, set, latch duty
// - Duty is low byte over duty bits
// - Pin clears when time base hits duty

`timescale 1ns/100ps

module cpw_top
	import cpw_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	input  wire logic [15:0] timer_count,
	input  wire logic        timer_tick,
	output logic             timer_clear,
	output logic             timer_ovf_block,
	input  wire logic [7:0]  period_count,
	input  wire logic [1:0]  period_phase,
	input  wire logic        period_tick,
	input  wire logic [7:0]  period_value,
	output logic             period_clear,
	input  wire logic        adc_enabled,
	output logic             adc_start,
	output logic [1:0]       event_flag,
	input  wire logic [2:0]  port_data,
	input  wire logic [2:0]  port_dir,
	output logic [2:0]       pin_out,
	output logic [2:0]       pin_oe
);

	cpw_ctrl_t  ctrl [2];
	logic [7:0] cmp_lo [2];
	logic [7:0] cmp_hi [2];
	logic [1:0] duty_lat [2];
	cpw_drv_t   drv [2];
	logic [1:0] wr_ctrl;
	logic [1:0] cmp_match;
	logic [1:0] trig;
	logic [1:0] duty_zero;
	logic [1:0] pwm_hit;
	logic [1:0] match_rise;
	logic       pwm_wrap;
	logic       alt_sel;
	logic       trig_q;

	// Shared period end for both channels
	assign pwm_wrap     = period_tick && (period_count == period_value);
	assign period_clear = pwm_wrap;

	// Identical channels over the shared timers
	for (genvar i = 0; i < 2; i++) begin : g_ch
		localparam logic CH = 1'(i);
		logic wr_lo;
		logic wr_hi;

		assign wr_ctrl[i] = reg_wr && (reg_addr == chan_ofs(OFS_CTRL, CH));
		assign wr_lo      = reg_wr && (reg_addr == chan_ofs(OFS_LOW, CH));
		assign wr_hi      = reg_wr && (reg_addr == chan_ofs(OFS_HIGH, CH));

		// Control register, two reserved bits dropped
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				ctrl[i] <= CTRL_RST;
			end else if (wr_ctrl[i]) begin
				ctrl[i] <= reg_wdata[5:0];
			end
		end

		// Low byte always writable; holds next duty in PWM
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				cmp_lo[i] <= CMP_RST;
			end else if (wr_lo) begin
				cmp_lo[i] <= reg_wdata;
			end
		end

		// High byte and hidden latch double buffer the duty
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				cmp_hi[i]   <= CMP_RST;
				duty_lat[i] <= LAT_RST;
			end else if (is_pwm(ctrl[i].mode)) begin
				if (pwm_wrap) begin
					cmp_hi[i]   <= cmp_lo[i];
					duty_lat[i] <= ctrl[i].duty_lo;
				end
			end else if (wr_hi) begin
				cmp_hi[i] <= reg_wdata;
			end
		end

		// Combinational compare so the trigger has no lag
		assign cmp_match[i] = is_compare(ctrl[i].mode) && (timer_count == {cmp_hi[i], cmp_lo[i]});
		assign trig[i]      = (ctrl[i].mode == MODE_TRIG) && cmp_match[i];
		assign duty_zero[i] = ({cmp_lo[i], ctrl[i].duty_lo} == 10'h000);
		// Ten-bit base against the latched duty
		assign pwm_hit[i]   = ({period_count, period_phase} == {cmp_hi[i], duty_lat[i]});

		cpw_channel u_chan (
			.sys_clk    (sys_clk),
			.rst        (rst),
			.ctrl       (ctrl[i]),
			.ctrl_wr    (wr_ctrl[i]),
			.wr_mode    (reg_wdata[3:0]),
			.cmp_match  (cmp_match[i]),
			.pwm_wrap   (pwm_wrap),
			.duty_zero  (duty_zero[i]),
			.pwm_hit    (pwm_hit[i]),
			.drv        (drv[i]),
			.match_rise (match_rise[i])
		);

		// Event flag: a match in the clearing cycle still lands
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				event_flag[i] <= 1'b0;
			end else if (match_rise[i]) begin
				event_flag[i] <= 1'b1;
			end else if (reg_wr && (reg_addr == OFS_FLAGS) && reg_wdata[i]) begin
				event_flag[i] <= 1'b0;
			end
		end
	end

	// Reset only if the match still holds at the timer's edge
	assign timer_clear     = (|trig) && timer_tick;
	// Lets the timer tell this reset from a rollover
	assign timer_ovf_block = timer_clear;

	// One start per trigger, second channel only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= trig[1];
		end
	end

	assign adc_start = trig[1] && !trig_q && adc_enabled;

	// Alternate pin selector
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alt_sel <= ALT_RST;
		end else if (reg_wr && (reg_addr == OFS_ALT)) begin
			alt_sel <= reg_wdata[0];
		end
	end

	// Read data stands one cycle; unmapped reads give zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == chan_ofs(OFS_CTRL, 1'b0)) begin
			reg_rdata <= {2'h0, ctrl[0]};
		end else if (reg_addr == chan_ofs(OFS_LOW, 1'b0)) begin
			reg_rdata <= cmp_lo[0];
		end else if (reg_addr == chan_ofs(OFS_HIGH, 1'b0)) begin
			reg_rdata <= cmp_hi[0];
		end else if (reg_addr == chan_ofs(OFS_CTRL, 1'b1)) begin
			reg_rdata <= {2'h0, ctrl[1]};
		end else if (reg_addr == chan_ofs(OFS_LOW, 1'b1)) begin
			reg_rdata <= cmp_lo[1];
		end else if (reg_addr == chan_ofs(OFS_HIGH, 1'b1)) begin
			reg_rdata <= cmp_hi[1];
		end else if (reg_addr == OFS_ALT) begin
			reg_rdata <= {7'h00, alt_sel};
		end else if (reg_addr == OFS_FLAGS) begin
			reg_rdata <= {6'h00, event_flag};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	cpw_pinmux u_pins (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.drv_a     (drv[0]),
		.drv_b     (drv[1]),
		.alt_sel   (alt_sel),
		.port_data (port_data),
		.port_dir  (port_dir),
		.pin_out   (pin_out),
		.pin_oe    (pin_oe)
	);

	// Checks on the first channel unless stated
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_zero_ctrl0;
		wr_ctrl[0] && (reg_wdata == 8'h00);
	endsequence

	sequence s_pwm_start0;
		is_pwm(ctrl[0].mode) && pwm_wrap && !duty_zero[0] && !wr_ctrl[0];
	endsequence

	sequence s_pwm_end0;
		is_pwm(ctrl[0].mode) && pwm_hit[0] && !pwm_wrap && !wr_ctrl[0];
	endsequence

	sequence s_trig_edge0;
		(ctrl[0].mode == MODE_TRIG) && cmp_match[0] && timer_tick;
	endsequence

	chk_zero_ctrl_low: assert property (
		s_zero_ctrl0 |=> !drv[0].out && !drv[0].drive ##1 pin_out[0] == port_data[0]
	) else $error("zero control write did not release pin");

	chk_swint_flag_only: assert property (
		(ctrl[0].mode == MODE_SWINT) && match_rise[0] && !reg_wr |=> event_flag[0] && !drv[0].drive
	) else $error("software event mode mishandled");

	chk_trig_timer_reset: assert property (
		s_trig_edge0 |-> timer_clear && timer_ovf_block && !drv[0].drive
	) else $error("trigger did not reset timer");

	chk_match_gone_noreset: assert property (
		timer_clear |-> timer_tick && (((ctrl[0].mode == MODE_TRIG) && (timer_count == {cmp_hi[0], cmp_lo[0]}))
			|| ((ctrl[1].mode == MODE_TRIG) && (timer_count == {cmp_hi[1], cmp_lo[1]})))
	) else $error("timer reset without live match");

	chk_trig_same_cycle: assert property (
		(ctrl[1].mode == MODE_TRIG) && cmp_match[1] && !$past(cmp_match[1]) && adc_enabled |-> adc_start
	) else $error("trigger or conversion start late");

	chk_adc_second_only: assert property (
		adc_start |-> (ctrl[1].mode == MODE_TRIG) && adc_enabled && !trig_q
	) else $error("conversion started without cause");

	chk_hi_read_only: assert property (
		is_pwm(ctrl[0].mode) && !pwm_wrap |=> cmp_hi[0] == $past(cmp_hi[0])
	) else $error("high byte changed in pwm mid period");

	chk_duty_copy_wrap: assert property (
		is_pwm(ctrl[0].mode) && pwm_wrap |=> {cmp_hi[0], duty_lat[0]} == $past({cmp_lo[0], ctrl[0].duty_lo})
	) else $error("duty not latched at period end");

	chk_pwm_set_pin: assert property (
		s_pwm_start0 |=> drv[0].out ##1 pin_out[0]
	) else $error("pwm pin not raised at period start");

	chk_pwm_clear_pin: assert property (
		s_pwm_end0 |=> !drv[0].out ##1 !pin_out[0]
	) else $error("pwm pin not cleared at duty match");

	chk_toggle_on_match: assert property (
		(ctrl[0].mode == MODE_TOGGLE) && match_rise[0] && !wr_ctrl[0] |=> drv[0].out != $past(drv[0].out)
	) else $error("toggle mode did not toggle");

	chk_alt_pin_route: assert property (
		alt_sel && drv[1].drive |=> pin_out[2] == $past(drv[1].out) && pin_out[1] == $past(port_data[1])
	) else $error("alternate pin routing wrong");

endmodule : cpw_top

// ==== test_compare_and_pwm_unit.sv ====
// Purpose: Self-checking bench for the two-channel compare and PWM unit
// Assumes: Bench models the sixteen-bit timer count and the period timer
// Notes:   Pin checks wait out the latch and pin register lag

`timescale 1ns/100ps

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp); end end

module test_compare_and_pwm_unit;
	import cpw_pkg::*;
	localparam int PR = 4;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [15:0] timer_count = 16'hFFFF;
	logic        timer_tick = 1'b0;
	logic        timer_clear;
	logic        timer_ovf_block;
	logic [7:0]  period_count = 8'h00;
	logic [1:0]  period_phase = 2'h0;
	logic        period_tick;
	logic [7:0]  period_value = 8'h00;
	logic        period_clear;
	logic        adc_enabled = 1'b0;
	logic        adc_start;
	logic [1:0]  event_flag;
	logic [2:0]  port_data = 3'h0;
	logic [2:0]  port_dir = 3'h7;
	logic [2:0]  pin_out;
	logic [2:0]  pin_oe;
	logic        pwm_run = 1'b0;
	int          rise_cnt, period_len, pulse_len, p1, r1, cyc;
	int          num_errors = 0;
	int          cmp_count = 0;

	always #2 sys_clk = ~sys_clk;

	cpw_top i_cpw_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_count(timer_count),
		.timer_tick(timer_tick), .timer_clear(timer_clear), .timer_ovf_block(timer_ovf_block),
		.period_count(period_count), .period_phase(period_phase), .period_tick(period_tick),
		.period_value(period_value), .period_clear(period_clear), .adc_enabled(adc_enabled),
		.adc_start(adc_start), .event_flag(event_flag), .port_data(port_data), .port_dir(port_dir),
		.pin_out(pin_out), .pin_oe(pin_oe));

	cpw_load i_cpw_load (.sys_clk(sys_clk), .pin_out(pin_out[0]), .pin_oe(pin_oe[0]),
		.rise_cnt(rise_cnt), .period_len(period_len), .pulse_len(pulse_len));

	// Period timer: phase counts every cycle, count steps on phase wrap
	assign period_tick = pwm_run && (period_phase == 2'h3);
	always @(posedge sys_clk) begin
		if (!pwm_run) begin
			period_count <= 8'h00;
			period_phase <= 2'h0;
		end else begin
			period_phase <= period_phase + 2'h1;
			if (period_clear)
				period_count <= 8'h00;
			else if (period_tick)
				period_count <= period_count + 8'h01;
		end
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// Hang guard well above the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask : rdchk

	task automatic tc(input logic [15:0] v);
		@(posedge sys_clk);
		timer_count <= v; // Synchronous timer
	endtask : tc

	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		for (int a = 0; a < 9; a++)
			rdchk(a[3:0], 8'h00);
		wr(4'h9, 8'hFF);
		rdchk(4'h9, 8'h00);
		wr(4'h0, 8'hFF);
		rdchk(4'h0, 8'h3F);
		wr(4'h0, 8'h00);
		// Set on match drives the pin high and raises the flag
		port_dir <= 3'h0;
		wr(4'h1, 8'h10);
		wr(4'h0, 8'h08);
		tc(16'h0010);
		repeat (4) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b1)
		`CHK(pin_oe[0], 1'b1)
		rdchk(4'h7, 8'h01);
		// Clearing control forces the latch low, port latch untouched
		tc(16'hFFFF);
		port_data <= 3'h1;
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h02);
		repeat (3) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b0)
		// Toggle on match, then clear on match from a preloaded high
		tc(16'h0010);
		repeat (4) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b1)
		tc(16'hFFFF);
		wr(4'h0, 8'h09);
		tc(16'h0010);
		repeat (4) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b0)
		tc(16'hFFFF);
		// Flag-only mode leaves the pin to the port latch
		wr(4'h7, 8'h03);
		wr(4'h0, 8'h0A);
		tc(16'h0010);
		repeat (4) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b1)
		rdchk(4'h7, 8'h01);
		// Second channel on the alternate pin
		wr(4'h6, 8'h01);
		port_data <= 3'h0;
		wr(4'h4, 8'h10);
		wr(4'h3, 8'h08);
		repeat (4) @(posedge sys_clk);
		`CHK(pin_out, 3'h4)
		rdchk(4'h7, 8'h03);
		`CHK(event_flag, 2'h3)
		// Special trigger on the second channel starts the converter
		tc(16'hFFFF);
		port_data <= 3'h4;
		wr(4'h3, 8'h0B);
		adc_enabled <= 1'b1;
		timer_tick  <= 1'b1;
		tc(16'h0010);
		@(negedge sys_clk);
		`CHK(timer_clear, 1'b1)
		`CHK(timer_ovf_block, 1'b1)
		`CHK(adc_start, 1'b1)
		repeat (3) @(posedge sys_clk);
		`CHK(pin_out[2], 1'b1)
		wr(4'h4, 8'h11);
		@(negedge sys_clk);
		`CHK(timer_clear, 1'b0)
		// First channel trigger never starts the converter
		wr(4'h3, 8'h00);
		tc(16'hFFFF);
		wr(4'h0, 8'h0B);
		tc(16'h0010);
		@(negedge sys_clk);
		`CHK(timer_clear, 1'b1)
		`CHK(adc_start, 1'b0)
		@(posedge sys_clk);
		timer_tick <= 1'b0;
		// PWM: duty 9 then 17, period from the period register
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h02);
		wr(4'h0, 8'h1C);
		period_value <= PR[7:0];
		pwm_run      <= 1'b1;
		repeat (100) @(posedge sys_clk);
		`CHK(period_len, 4 * (PR + 1))
		@(negedge sys_clk iff period_clear);
		`CHK({period_count, period_phase}, {PR[7:0], 2'h3})
		p1 = pulse_len;
		rdchk(4'h2, 8'h02);
		wr(4'h2, 8'h55);
		rdchk(4'h2, 8'h02);
		wr(4'h1, 8'h04);
		repeat (60) @(posedge sys_clk);
		`CHK(pulse_len - p1, 8)
		// Zero duty never sets the pin
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h0C);
		repeat (30) @(posedge sys_clk);
		r1 = rise_cnt;
		repeat (60) @(posedge sys_clk);
		`CHK(rise_cnt, r1)
		// Clearing control hands the pin back to the port latch
		port_data <= 3'h1;
		wr(4'h0, 8'h00);
		repeat (3) @(posedge sys_clk);
		`CHK(pin_out[0], 1'b1)
		print_verdict();
	end
endmodule : test_compare_and_pwm_unit
